// ==== shared/tias_defs.svh ====
`ifndef TIAS_DEFS_SVH
`define TIAS_DEFS_SVH

// datapath widths
`define TIAS_WORD_W      48
`define TIAS_OPND_W      18
`define TIAS_PROD_W      36
`define TIAS_SHIFT_BITS  17
`define TIAS_OPSEL_W     7
`define TIAS_PICK_W      2

// operation select field positions
`define TIAS_ZSEL_HI     6
`define TIAS_ZSEL_LO     4
`define TIAS_YSEL_HI     3
`define TIAS_YSEL_LO     2
`define TIAS_XSEL_HI     1
`define TIAS_XSEL_LO     0

// third selector codes
`define TIAS_Z_ZERO      3'h0
`define TIAS_Z_CASC      3'h1
`define TIAS_Z_RESULT    3'h2
`define TIAS_Z_CBUS      3'h3
`define TIAS_Z_CASC_SH   3'h5
`define TIAS_Z_RES_SH    3'h6

// second selector codes
`define TIAS_Y_ZERO      2'h0
`define TIAS_Y_PROD      2'h1
`define TIAS_Y_CBUS      2'h3

// first selector codes
`define TIAS_X_ZERO      2'h0
`define TIAS_X_PROD      2'h1
`define TIAS_X_RESULT    2'h2
`define TIAS_X_CONCAT    2'h3

// carry source codes
`define TIAS_CS_FABRIC   2'h0
`define TIAS_CS_MSB      2'h1
`define TIAS_CS_ROUND    2'h2
`define TIAS_CS_ROUND_D  2'h3

// register port
`define TIAS_ADDR_W      4
`define TIAS_DATA_W      32
`define TIAS_REG_CFG     4'h0
`define TIAS_REG_RES_LO  4'h4
`define TIAS_REG_RES_HI  4'h8
`define TIAS_REG_STATUS  4'hC
`define TIAS_CFG_CARRY_REG_BIT  0
`define TIAS_CFG_PROD_STAGE_BIT 1
`define TIAS_CFG_RESET   2'h0
`define TIAS_RESULT_RESET 48'h000000000000

`endif

// ==== shared/tias_pkg.sv ====
`default_nettype none
package tias_pkg;

`include "tias_defs.svh"

    typedef logic [`TIAS_WORD_W-1:0] tias_word_t;

    // control fields driven by fabric logic each cycle
    typedef struct packed {
        logic [`TIAS_OPSEL_W-1:0] opSel;
        logic                     subtract;
        logic [`TIAS_PICK_W-1:0]  carryPick;
        logic                     fabricCarry;
    } tias_ctrl_t;

    // data operands
    typedef struct packed {
        logic [`TIAS_OPND_W-1:0] a;
        logic [`TIAS_OPND_W-1:0] b;
        tias_word_t              cBus;
        tias_word_t              cascadeIn;
    } tias_oper_t;

    // software configuration
    typedef struct packed {
        logic productStage;
        logic fabricCarryReg;
    } tias_cfg_t;

    // register port request
    typedef struct packed {
        logic [`TIAS_ADDR_W-1:0] addr;
        logic [`TIAS_DATA_W-1:0] wrData;
        logic                    wrStb;
        logic                    rdStb;
    } tias_req_t;

endpackage
`default_nettype wire

// ==== hw/tias_product.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tias_defs.svh"
module tias_product (
    input  wire logic                               clock,
    input  wire logic                               clockEn,
    input  wire logic                               rst_n,
    input  wire logic                               stageEn,
    input  wire logic [`TIAS_OPND_W-1:0]            a,
    input  wire logic [`TIAS_OPND_W-1:0]            b,
    output logic      [`TIAS_PROD_W-1:0]            partOne,
    output logic      [`TIAS_PROD_W-1:0]            partTwo
);
    import tias_pkg::*;

    logic signed [27:0]          loProd;
    logic signed [26:0]          hiProd;
    logic [`TIAS_PROD_W-1:0]     partOneComb;
    logic [`TIAS_PROD_W-1:0]     partTwoComb;
    logic [`TIAS_PROD_W-1:0]     partOne_q;
    logic [`TIAS_PROD_W-1:0]     partTwo_q;

    // split b so the two partial products sum to the full signed product
    assign loProd      = $signed(a) * $signed({1'b0, b[8:0]});
    assign hiProd      = $signed(a) * $signed(b[17:9]);
    assign partOneComb = {{8{loProd[27]}}, loProd};
    assign partTwoComb = {hiProd, 9'h000};

    // optional product stage register, one cycle of latency
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            partOne_q <= 36'h000000000;
            partTwo_q <= 36'h000000000;
        end else if (clockEn) begin
            partOne_q <= partOneComb;
            partTwo_q <= partTwoComb;
        end
    end

    // stage bypass is picked by configuration
    assign partOne = stageEn ? partOne_q : partOneComb;
    assign partTwo = stageEn ? partTwo_q : partTwoComb;

endmodule
`default_nettype wire

// ==== hw/tias_adder.sv ====
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// [RQ1] result is z plus or minus (x+y+carry)
// [RQ2] subtract high subtracts, low adds
// [RQ3] seven-bit select: z 6:4, y 3:2, x 1:0
// [RQ4] z picks zero, cascade, result, c, shifted
// [RQ5] x zero/result/concat, y zero/c bus
// [RQ6] x and y 01 feed both partial products
// [RQ7] caller avoids reserved selector codes
// [RQ8] shifted inputs are arithmetic right 17
// [RQ9] 48-bit words, 36-bit operands sign-extended
// [RQ10] carry chosen from four sources
// [RQ11] code 00 fabric carry, optionally registered
// [RQ12] code 01 inverted msb of result/cascade
// [RQ13] code 10 rounding bit from operands
// [RQ14] code 11 registered copy of code 10
// [RQ15] caller keeps select fields consistent
// [RQ16] carry enters at lsb of x+y
// [RQ17] 48-bit two's complement, overflow dropped
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
`include "tias_defs.svh"
module tias_adder (
    input  wire logic                               clock,
    input  wire logic                               arst_n,
    input  wire logic                               clockEn,
    input  wire tias_pkg::tias_ctrl_t               ctrl,
    input  wire tias_pkg::tias_oper_t               oper,
    input  wire tias_pkg::tias_req_t                req,
    output logic      [`TIAS_DATA_W-1:0]            rdData,
    output tias_pkg::tias_word_t                    result,
    output tias_pkg::tias_word_t                    cascadeOut,
    output logic                                    reservedSeen
);
    import tias_pkg::*;

    //////////////////////////////////////////////////////////////////////////
    // declarations

    logic                        rstMeta_q;
    logic                        rstSync_q;
    tias_cfg_t                   cfg_q;
    tias_word_t                  result_q;
    tias_word_t                  cascadeOut_q;
    logic [`TIAS_DATA_W-1:0]     rdData_q;
    logic                        fabricCarry_q;
    logic                        roundDelay_q;
    logic                        lastCarry_q;
    logic                        reserved_q;

    logic [2:0]                  zSel;
    logic [1:0]                  ySel;
    logic [1:0]                  xSel;
    logic                        prodPicked;
    logic                        concatPicked;
    logic                        zReserved;
    logic                        yReserved;

    logic [`TIAS_PROD_W-1:0]     partOne;
    logic [`TIAS_PROD_W-1:0]     partTwo;
    tias_word_t                  zOut;
    tias_word_t                  yOut;
    tias_word_t                  xOut;
    tias_word_t                  shiftCasc;
    tias_word_t                  shiftRes;
    tias_word_t                  xySum;
    tias_word_t                  sumNext;

    logic                        fabricSrc;
    logic                        msbSrc;
    logic                        roundSrc;
    logic                        adderCarry;

    //////////////////////////////////////////////////////////////////////////
    // helpers

    // widen a 36-bit signed value to the word width
    function automatic tias_word_t sext36(input logic [`TIAS_PROD_W-1:0] v);
        sext36 = {{(`TIAS_WORD_W-`TIAS_PROD_W){v[`TIAS_PROD_W-1]}}, v};
    endfunction

    // arithmetic right shift by the cascade alignment distance
    function automatic tias_word_t ashr17(input tias_word_t v);
        ashr17 = {{`TIAS_SHIFT_BITS{v[`TIAS_WORD_W-1]}},
                  v[`TIAS_WORD_W-1:`TIAS_SHIFT_BITS]};
    endfunction

    //////////////////////////////////////////////////////////////////////////
    // reset release: asserted at once, removed after two edges

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rstMeta_q <= 1'b0;
            rstSync_q <= 1'b0;
        end else if (clockEn) begin
            rstMeta_q <= 1'b1;
            rstSync_q <= rstMeta_q;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // select field decode

    // [RQ3] field split
    assign zSel = ctrl.opSel[`TIAS_ZSEL_HI:`TIAS_ZSEL_LO];
    assign ySel = ctrl.opSel[`TIAS_YSEL_HI:`TIAS_YSEL_LO];
    assign xSel = ctrl.opSel[`TIAS_XSEL_HI:`TIAS_XSEL_LO];

    // [RQ6] product pairing
    assign prodPicked   = (xSel == `TIAS_X_PROD) && (ySel == `TIAS_Y_PROD);
    assign concatPicked = (xSel == `TIAS_X_CONCAT);

    // [RQ7] flag reserved codes; they read as zero, never trust them
    assign zReserved = (zSel == 3'h4) || (zSel == 3'h7);
    assign yReserved = (ySel == 2'h2) || ((ySel == `TIAS_Y_PROD) != (xSel == `TIAS_X_PROD));

    //////////////////////////////////////////////////////////////////////////
    // multiplier partial products, staging picked by configuration

    tias_product u_product (
        .clock   (clock),
        .clockEn (clockEn),
        .rst_n   (rstSync_q),
        .stageEn (cfg_q.productStage),
        .a       (oper.a),
        .b       (oper.b),
        .partOne (partOne),
        .partTwo (partTwo)
    );

    //////////////////////////////////////////////////////////////////////////
    // operand selectors

    // [RQ8] shift by 17
    assign shiftCasc = ashr17(oper.cascadeIn);
    assign shiftRes  = ashr17(result_q);

    // [RQ4] third selector
    always_comb begin
        case (zSel)
            `TIAS_Z_ZERO:    zOut = '0;
            `TIAS_Z_CASC:    zOut = oper.cascadeIn;
            `TIAS_Z_RESULT:  zOut = result_q;
            `TIAS_Z_CBUS:    zOut = oper.cBus;
            `TIAS_Z_CASC_SH: zOut = shiftCasc;
            `TIAS_Z_RES_SH:  zOut = shiftRes;
            default:         zOut = '0;
        endcase
    end

    // [RQ5] second selector
    // [RQ9] products widened
    always_comb begin
        case (ySel)
            `TIAS_Y_ZERO: yOut = '0;
            `TIAS_Y_PROD: yOut = prodPicked ? sext36(partTwo) : '0;
            `TIAS_Y_CBUS: yOut = oper.cBus;
            default:      yOut = '0;
        endcase
    end

    // [RQ5] first selector
    // [RQ9] concat widened
    always_comb begin
        case (xSel)
            `TIAS_X_ZERO:   xOut = '0;
            `TIAS_X_PROD:   xOut = prodPicked ? sext36(partOne) : '0;
            `TIAS_X_RESULT: xOut = result_q;
            `TIAS_X_CONCAT: xOut = sext36({oper.a, oper.b});
            default:        xOut = '0;
        endcase
    end

    //////////////////////////////////////////////////////////////////////////
    // carry source logic

    // [RQ11] fabric carry path
    assign fabricSrc = cfg_q.fabricCarryReg ? fabricCarry_q : ctrl.fabricCarry;

    // [RQ12] msb by op bit 4
    // bit 6 only adds the shift; the msb is the same shifted or not
    assign msbSrc = ctrl.opSel[4] ? ~oper.cascadeIn[`TIAS_WORD_W-1]
                                  : ~result_q[`TIAS_WORD_W-1];

    // [RQ13] rounding bit
    always_comb begin
        if (prodPicked)
            roundSrc = ~(oper.a[`TIAS_OPND_W-1] ^ oper.b[`TIAS_OPND_W-1]);
        else if (concatPicked)
            roundSrc = ~oper.a[`TIAS_OPND_W-1];
        else
            roundSrc = 1'b0;
    end

    // [RQ10] four-way carry pick
    always_comb begin
        case (ctrl.carryPick)
            `TIAS_CS_FABRIC:  adderCarry = fabricSrc;
            `TIAS_CS_MSB:     adderCarry = msbSrc;
            `TIAS_CS_ROUND:   adderCarry = roundSrc;
            `TIAS_CS_ROUND_D: adderCarry = roundDelay_q;
            default:          adderCarry = 1'b0;
        endcase
    end

    // [RQ11] carry input register
    // [RQ14] delayed rounding bit
    always_ff @(posedge clock or negedge rstSync_q) begin
        if (!rstSync_q) begin
            fabricCarry_q <= 1'b0;
            roundDelay_q  <= 1'b0;
        end else if (clockEn) begin
            fabricCarry_q <= ctrl.fabricCarry;
            roundDelay_q  <= roundSrc;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // adder/subtracter

    // [RQ16] carry at lsb
    assign xySum = xOut + yOut + {{(`TIAS_WORD_W-1){1'b0}}, adderCarry};

    // [RQ1] combine with z
    // [RQ2] subtract control
    // [RQ17] wrap at 48 bits
    assign sumNext = ctrl.subtract ? (zOut - xySum) : (zOut + xySum);

    // result register feeds accumulate paths; a twin register loaded with the same sum drives the cascade output
    always_ff @(posedge clock or negedge rstSync_q) begin
        if (!rstSync_q) begin
            result_q     <= `TIAS_RESULT_RESET;
            cascadeOut_q <= `TIAS_RESULT_RESET;
            lastCarry_q  <= 1'b0;
            reserved_q   <= 1'b0;
        end else if (clockEn) begin
            result_q     <= sumNext;
            cascadeOut_q <= sumNext;
            lastCarry_q  <= adderCarry;
            reserved_q   <= zReserved || yReserved;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // register port

    // configuration write; other offsets ignore writes
    always_ff @(posedge clock or negedge rstSync_q) begin
        if (!rstSync_q) begin
            cfg_q <= `TIAS_CFG_RESET;
        end else if (clockEn && req.wrStb && req.addr == `TIAS_REG_CFG) begin
            cfg_q.fabricCarryReg <= req.wrData[`TIAS_CFG_CARRY_REG_BIT];
            cfg_q.productStage   <= req.wrData[`TIAS_CFG_PROD_STAGE_BIT];
        end
    end

    // read data stands for one cycle after the strobe, zero otherwise
    always_ff @(posedge clock or negedge rstSync_q) begin
        if (!rstSync_q) begin
            rdData_q <= '0;
        end else if (clockEn) begin
            if (req.rdStb) begin
                case (req.addr)
                    `TIAS_REG_CFG:    rdData_q <= {30'h0, cfg_q};
                    `TIAS_REG_RES_LO: rdData_q <= result_q[31:0];
                    `TIAS_REG_RES_HI: rdData_q <= {16'h0000, result_q[47:32]};
                    `TIAS_REG_STATUS: rdData_q <= {30'h0, reserved_q,
                                                   lastCarry_q};
                    default:          rdData_q <= '0;
                endcase
            end else begin
                rdData_q <= '0;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // outputs, all straight from flops

    assign rdData       = rdData_q;
    assign result       = result_q;
    assign cascadeOut   = cascadeOut_q;
    assign reservedSeen = reserved_q;

endmodule
`default_nettype wire

// ==== verif/tias_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tias_defs.svh"
module tias_asserts (
    input wire logic                    clock,
    input wire logic                    arst_n,
    input wire logic                    clockEn,
    input wire tias_pkg::tias_ctrl_t    ctrl,
    input wire tias_pkg::tias_oper_t    oper,
    input wire tias_pkg::tias_req_t     req,
    input wire logic [`TIAS_DATA_W-1:0] rdData,
    input wire tias_pkg::tias_word_t    result,
    input wire tias_pkg::tias_word_t    cascadeOut,
    input wire logic                    reservedSeen
);
    import tias_pkg::*;
    logic [1:0] upQ, cfgQ;
    logic       nA, nC, nP, rnd;
    tias_word_t abW, catT, prdT, shT, accT, fabT;
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);
    function automatic tias_word_t fin(logic s, tias_word_t z, tias_word_t t);
        return s ? z - t : z + t;
    endfunction
    // track reset release and config from the ports; internals are out of reach
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            upQ <= 2'h0;
            cfgQ <= 2'h0;
        end else if (clockEn) begin
            upQ <= {upQ[0], 1'b1};
            if (req.wrStb && req.addr == `TIAS_REG_CFG) begin
                cfgQ <= req.wrData[1:0];
            end
        end
    end
    // one-bit carries kept in variables so no inversion widens to 48 bits
    always_comb begin
        nA = ~oper.a[17];
        nC = ~oper.cascadeIn[47];
        nP = ~result[47];
        rnd = ctrl.opSel[3:0] == 4'h5 ? ~(oper.a[17] ^ oper.b[17]) : ctrl.opSel[1:0] == 2'h3 && nA;
        abW = {{12{oper.a[17]}}, oper.a, oper.b};
        catT = fin(ctrl.subtract, '0, abW + nA);
        prdT = $signed(oper.a) * $signed(oper.b);
        prdT = fin(ctrl.subtract, '0, prdT + rnd);
        shT = $signed(oper.cascadeIn) >>> 17;
        shT = fin(ctrl.subtract, shT, nC);
        accT = fin(ctrl.subtract, result, nP);
        fabT = fin(ctrl.subtract, '0, ctrl.fabricCarry);
    end
    ////////////////////////////////////////////////////////////
    sequence opGo(logic [6:0] s, logic [1:0] p);
        upQ[1] && clockEn && ctrl.opSel == s && ctrl.carryPick == p;
    endsequence
    a_concat_round: assert property (opGo(7'h03, 2'h2) |=> result == $past(catT))
        else $error("concat sum wrong");
    a_product_sum: assert property (opGo(7'h05, 2'h2) ##0 !cfgQ[1] |=> result == $past(prdT))
        else $error("product sum wrong");
    a_fabric_carry: assert property (opGo(7'h00, 2'h0) ##0 !cfgQ[0] |=> result == $past(fabT))
        else $error("fabric carry sum wrong");
    a_shift_casc: assert property (opGo(7'h50, 2'h1) |=> result == $past(shT))
        else $error("shifted cascade sum wrong");
    a_accum_msb: assert property (opGo(7'h20, 2'h1) |=> result == $past(accT))
        else $error("accumulate sum wrong");
    a_carry_late: assert property (opGo(7'h03, 2'h2) ##1 opGo(7'h03, 2'h3) ##0 !ctrl.subtract
        |=> result == $past(abW) + {47'h0, $past(rnd, 2)})
        else $error("delayed carry sum wrong");
    a_reserved_flag: assert property (upQ[1] && clockEn
        && (ctrl.opSel[6:4] == 3'h4 || ctrl.opSel[3:2] == 2'h2) |=> reservedSeen)
        else $error("reserved code not flagged");
    a_read_idle: assert property (upQ[1] && clockEn && (!req.rdStb || req.addr[1:0] != 2'h0)
        |=> rdData == '0)
        else $error("read data not zero");
    a_cfg_read: assert property (upQ[1] && clockEn && req.rdStb && req.addr == `TIAS_REG_CFG
        |=> rdData == {30'h0, $past(cfgQ)})
        else $error("config readback wrong");
    a_casc_copy: assert property (upQ[1] |-> cascadeOut == result)
        else $error("cascade copy differs");
endmodule
`default_nettype wire

// ==== verif/tias_partner.sv ====
`timescale 1ns/1ps
`default_nettype none
module tias_partner (
    input wire logic           clock,
    input wire logic           valid,
    input wire logic           allowBad,
    input wire tias_pkg::tias_ctrl_t cmdCtrl,
    input wire tias_pkg::tias_oper_t cmdOper,
    output var tias_pkg::tias_ctrl_t ctrl,
    output var tias_pkg::tias_oper_t oper
);
    import tias_pkg::*;
    tias_oper_t lastQ;
    logic       bad;
    // an idle fabric bus shows the inverse of its last value, never a stale copy
    always_ff @(posedge clock) begin
        if (valid) begin
            lastQ <= cmdOper;
        end
    end
    assign bad = cmdCtrl.opSel[6:4] == 3'h4 || cmdCtrl.opSel[6:4] == 3'h7
        || cmdCtrl.opSel[3:2] == 2'h2;
    // idle feeds the result back with fabric carry 0; a registered fabric carry still lands on the first idle cycle
    always_comb begin
        oper = valid ? cmdOper : ~lastQ;
        ctrl = '0;
        ctrl.opSel = 7'h20;
        if (valid && (!bad || allowBad)) begin
            ctrl = cmdCtrl;
        end
    end
endmodule
`default_nettype wire

// ==== verif/tb_three_input_adder_carry_select.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tias_defs.svh"
module tb_three_input_adder_carry_select;
    import tias_pkg::*;
    typedef struct {tias_word_t v; int due; int kind;} tias_note_t;
    logic        clock, arst_n, clockEn, valid, allowBad, reservedSeen, rPrev, fPrev;
    tias_ctrl_t  cmdCtrl, ctrl;
    tias_oper_t  cmdOper, oper, lastO;
    tias_req_t   req;
    tias_word_t  result, cascadeOut, pM, pPrev;
    logic [31:0] rdData, seed;
    logic [1:0]  cfg;
    tias_note_t  q[$];
    int          num_errors, num_checks, cyc;
    logic [2:0]  zs[6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
    logic [3:0]  xys[7] = '{4'h0, 4'h2, 4'h3, 4'h5, 4'hC, 4'hE, 4'hF};
    logic [6:0]  bads[5] = '{7'h40, 7'h70, 7'h08, 7'h01, 7'h04};
    string       nm[3] = '{"result", "rdData", "reservedSeen"};
    tias_partner fab (.clock(clock), .valid(valid), .allowBad(allowBad), .cmdCtrl(cmdCtrl),
        .cmdOper(cmdOper), .ctrl(ctrl), .oper(oper));
    tias_adder dut (.clock(clock), .arst_n(arst_n), .clockEn(clockEn), .ctrl(ctrl), .oper(oper),
        .req(req), .rdData(rdData), .result(result), .cascadeOut(cascadeOut),
        .reservedSeen(reservedSeen));
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    // one datapath cycle with random operands; the reference sum is kept in pM
    task automatic op(input logic [6:0] s, input logic sub, input logic [1:0] pk, input logic en);
        tias_word_t x, y, z, ab, pNow;
        logic       adder_carry, rnd, bad, fc;
        tias_oper_t o;
        o = 132'({xs(), xs(), xs(), xs(), xs()});
        fc = seed[9];
        ab = {{12{o.a[17]}}, o.a, o.b};
        case (s[6:4])
            3'h1: z = o.cascadeIn;
            3'h2: z = pM;
            3'h3: z = o.cBus;
            3'h5: z = $signed(o.cascadeIn) >>> `TIAS_SHIFT_BITS;
            3'h6: z = $signed(pM) >>> `TIAS_SHIFT_BITS;
            default: z = '0;
        endcase
        x = s[1:0] == 2'h2 ? pM : s[1:0] == 2'h3 ? ab : '0;
        y = s[3:2] == 2'h3 ? o.cBus : '0;
        rnd = s[1:0] == 2'h3 && ~o.a[17];
        // product over both selectors, one enabled cycle late with the product stage
        pNow = $signed(o.a) * $signed(o.b);
        if (s[3:0] == 4'h5) begin
            x = cfg[1] ? pPrev : pNow;
            rnd = ~(o.a[17] ^ o.b[17]);
        end
        // rounding carry only beside product or concat
        if (pk[1] && !(s[3:0] == 4'h5 || s[1:0] == 2'h3)) begin
            pk = 2'h0;
        end
        case (pk)
            2'h0: adder_carry = cfg[0] ? fPrev : fc;
            2'h1: adder_carry = s[4] ? ~o.cascadeIn[47] : ~pM[47];
            2'h2: adder_carry = rnd;
            default: adder_carry = rPrev;
        endcase
        bad = s[6:4] == 3'h4 || s[6:4] == 3'h7 || s[3:2] == 2'h2 || (s[1:0] == 2'h1) != (s[3:2] == 2'h1);
        @(posedge clock);
        cmdCtrl <= '{s, sub, pk, fc};
        cmdOper <= o;
        valid <= 1'b1;
        clockEn <= en;
        lastO = o;
        if (en) begin
            // carry joins x+y, wraps at 48 bits
            pM = sub ? z - (x + y + adder_carry) : z + x + y + adder_carry;
            rPrev = rnd;
            fPrev = fc;
            pPrev = pNow;
            q.push_back('{48'(bad), cyc + 1, 2});
        end
        q.push_back('{pM, cyc + 1, 0});
    endtask
    task automatic idle(input int n);
        // the partner shows the inverted last operands while idle
        pPrev = $signed(~lastO.a) * $signed(~lastO.b);
        if (cfg[0]) begin
            pM = pM + fPrev;
        end
        repeat (n) begin
            @(posedge clock);
            valid <= 1'b0;
            clockEn <= 1'b1;
        end
        rPrev = 1'b0;
        fPrev = 1'b0;
    endtask
    // register port access; for a read d is the expected data
    task automatic rw(input logic wr, input logic [3:0] ad, input logic [31:0] d);
        @(posedge clock);
        req <= '{ad, d, wr, !wr};
        if (!wr) begin
            q.push_back('{48'(d), cyc + 1, 1});
        end else if (ad == `TIAS_REG_CFG) begin
            cfg = d[1:0];
        end
        @(posedge clock);
        req.wrStb <= 1'b0;
        req.rdStb <= 1'b0;
    endtask
    // oldest note against the outputs of the cycle it is due in
    always @(negedge clock) begin
        tias_word_t got;
        while (q.size() > 0 && q[0].due == cyc) begin
            got = q[0].kind == 0 ? result : q[0].kind == 1 ? 48'(rdData) : 48'(reservedSeen);
            num_checks++;
            if (got !== q[0].v) begin
                num_errors++;
                $display("FAIL %s expected %h seen %h", nm[q[0].kind], q[0].v, got);
            end
            if (q[0].kind == 0 && cascadeOut !== q[0].v) begin
                num_errors++;
                $display("FAIL cascadeOut expected %h seen %h", q[0].v, cascadeOut);
            end
            void'(q.pop_front());
        end
        cyc = cyc + 1;
        if (cyc > 2000) begin
            num_errors++;
            tally_and_finish();
        end
    end
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        {arst_n, valid, allowBad, rPrev, fPrev, cfg, cyc, num_errors, num_checks} = '0;
        {cmdCtrl, cmdOper, req, pM, pPrev, lastO} = '0;
        clockEn = 1'b1;
        seed = 32'h00000048;
        repeat (5) @(posedge clock);
        arst_n <= 1'b1;
        idle(3);
        // every legal code back to back; the rounding sources only beside product or concat, other codes take fabric carry there
        for (int k = 0; k < 168; k++) begin
            op({zs[k % 42 / 7], xys[k % 7]}, k[0], 2'(k / 42), 1'b1);
        end
        op(7'h03, 1'b0, 2'h2, 1'b1);
        op(7'h03, 1'b0, 2'h3, 1'b1);
        op(7'h22, 1'b1, 2'h1, 1'b0);
        idle(2);
        allowBad <= 1'b1;
        foreach (bads[i]) op(bads[i], 1'b1, 2'h1, 1'b1);
        op(7'h33, 1'b0, 2'h2, 1'b1);
        allowBad <= 1'b0;
        idle(2);
        rw(1'b0, `TIAS_REG_RES_LO, pM[31:0]);
        rw(1'b0, `TIAS_REG_RES_HI, {16'h0, pM[47:32]});
        rw(1'b1, `TIAS_REG_RES_LO, 32'h12345678);
        rw(1'b0, `TIAS_REG_RES_LO, pM[31:0]);
        rw(1'b0, 4'h2, 32'h0);
        rw(1'b0, `TIAS_REG_STATUS, 32'h0);
        rw(1'b1, `TIAS_REG_CFG, 32'h3);
        rw(1'b0, `TIAS_REG_CFG, 32'h3);
        rw(1'b1, `TIAS_REG_CFG, 32'h1);
        // registered fabric carry lags by one enabled cycle
        repeat (4) op(7'h0E, 1'b0, 2'h0, 1'b1);
        idle(2);
        // product stage on: products land one enabled cycle late
        rw(1'b1, `TIAS_REG_CFG, 32'h2);
        repeat (3) op(7'h25, 1'b0, 2'h3, 1'b1);
        idle(2);
        rw(1'b1, `TIAS_REG_CFG, 32'h0);
        rw(1'b0, `TIAS_REG_CFG, 32'h0);
        repeat (4) @(posedge clock);
        if (q.size() != 0) begin
            num_errors++;
        end
        tally_and_finish();
    end
endmodule
bind tias_adder tias_asserts chk (.clock(clock), .arst_n(arst_n), .clockEn(clockEn),
    .ctrl(ctrl), .oper(oper), .req(req), .rdData(rdData), .result(result),
    .cascadeOut(cascadeOut), .reservedSeen(reservedSeen));
`default_nettype wire
